//--- cab_core.sv
// Addressing, branch and flag core with AXI4-Lite control port
`timescale 1ns/100ps
`include "cab_regs.svh"

// Notes on behaviour
// RULE1: Flag snapshot puts C, C xor V, stack full, stack empty in A[7:4].
// RULE2: Shift-into-carry: A gets operand shifted left, zero in, old bit 7 to C.
// RULE3: Clock-divide selects undivided, /2, /4, /8 or /16; flags kept.
// RULE4: Eight operand modes; direct address is zero high byte and 8-bit field.
// RULE5: Extended operand access and pointer update happen in one instruction.
// RULE6: Immediate offset mode reads pointer plus offset, pointer unchanged.
// RULE7: Register offset mode reads pointer plus third general register.
// RULE8: Post-increment reads at pointer, then pointer gains one.
// RULE9: Post-offset mode reads pointer plus offset and stores that sum back.
// RULE10: Pre-decrement reads pointer minus one and keeps that value.
// RULE11: Pre-offset-decrement reads pointer minus offset and keeps it.
// RULE12: Jump conditions on C, Z, V set or clear, and either event line.
// RULE13: After compare: equal, unequal, greater, at least, less, at most.
// RULE14: Separate instruction and data ports, usable in the same cycle.
// RULE15: Instruction port spans 8192 words of 22 bits.
// RULE16: Data space: 8 low-power regs, peripheral region, 512 bytes RAM.
// RULE17: Sixteen internal registers, apart from data memory.
// RULE18: Compare subtracts first from second; C clear on underflow; V = C and not Z.
// RULE19: Halt stops fetch until interrupt, event or reset; state kept.
module cab_core
  import cab_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  output logic [`CAB_PCW-1:0]      imem_addr,
  input  wire logic [`CAB_IW-1:0]  imem_data,
  output logic [`CAB_DAW-1:0]      dm_addr,
  output logic [7:0]               dm_wdata,
  input  wire logic [7:0]          dm_rdata,
  output logic                     dm_re,
  output logic                     dm_we,
  input  wire logic                event_line_zero,
  input  wire logic                event_line_one,
  input  wire logic                wake_irq,
  input  wire logic                hardware_call_stack_full,
  input  wire logic                hardware_call_stack_empty,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] cab_ptr(input logic [15:0][7:0] rf, input logic [1:0] sel);
    logic [3:0] lo;
    lo = `CAB_RF_PTR0 + {1'b0, sel, 1'b0};
    cab_ptr = {rf[lo + 4'h1], rf[lo]};
  endfunction : cab_ptr

  // Upper half is the access address, lower half the new pointer
  function automatic logic [31:0] cab_eaddr(input cab_mode_t m, input logic [15:0] p,
                                            input logic [7:0] o, input logic [7:0] t);
    logic [15:0] po;
    logic [15:0] mo;
    po = p + {8'h00, o};
    mo = p - {8'h00, o};
    unique case (m)
      // RULE4 direct page
      CAB_M_DIRECT:  cab_eaddr = {`CAB_DIRECT_HI, o, p};
      CAB_M_PTR:     cab_eaddr = {p, p};
      // RULE6 offset, pointer kept
      CAB_M_PTROFF:  cab_eaddr = {po, p};
      // RULE7 third register offset
      CAB_M_PTRTHRD: cab_eaddr = {p + {8'h00, t}, p};
      // RULE8 post increment
      CAB_M_POSTINC: cab_eaddr = {p, p + 16'h0001};
      // RULE9 post add offset
      CAB_M_POSTOFF: cab_eaddr = {po, po};
      // RULE10 pre decrement
      CAB_M_PREDEC:  cab_eaddr = {p - 16'h0001, p - 16'h0001};
      // RULE11 pre subtract offset
      CAB_M_PREOFF:  cab_eaddr = {mo, mo};
    endcase
  endfunction : cab_eaddr

  function automatic logic cab_mem_op(input logic [3:0] op);
    cab_mem_op = (op == CAB_LD) || (op == CAB_STORE) || (op == CAB_CMP) || (op == CAB_RFLM);
  endfunction : cab_mem_op

  // RULE16 mapped data space
  function automatic logic cab_dm_ok(input logic [15:0] a);
    cab_dm_ok = (a <= `CAB_LP_TOP) || ((a >= `CAB_PER_BASE) && (a <= `CAB_RAM_TOP));
  endfunction : cab_dm_ok

  // RULE18 compare flags, returns C, V, Z, difference
  function automatic logic [10:0] cab_cmp(input logic [7:0] op2, input logic [7:0] op1);
    logic [8:0] d;
    logic       cy;
    logic       ze;
    d  = {1'b0, op2} - {1'b0, op1};
    cy = !d[8];
    ze = (d[7:0] == 8'h00);
    cab_cmp = {cy, cy & !ze, ze, d[7:0]};
  endfunction : cab_cmp

  // RULE2 shift into carry, returns C, Z, result
  function automatic logic [9:0] cab_shl(input logic [7:0] x);
    cab_shl = {x[7], (x[6:0] == 7'h00), x[6:0], 1'b0};
  endfunction : cab_shl

  function automatic logic cab_cond(input cab_cond_t k, input logic c, input logic v,
                                    input logic z, input logic e);
    case (k)
      // RULE12 flag and event tests
      CAB_C_CS:    cab_cond = c;
      CAB_C_CC:    cab_cond = !c;
      CAB_C_ZS:    cab_cond = z;
      CAB_C_ZC:    cab_cond = !z;
      CAB_C_VS:    cab_cond = v;
      CAB_C_VC:    cab_cond = !v;
      CAB_C_EVENT: cab_cond = e;
      // RULE13 ordered compare tests
      CAB_C_EQ:    cab_cond = z;
      CAB_C_NE:    cab_cond = !z;
      CAB_C_GT:    cab_cond = !c;
      CAB_C_GE:    cab_cond = !v;
      CAB_C_LT:    cab_cond = v;
      CAB_C_LE:    cab_cond = c;
      default:     cab_cond = 1'b0;
    endcase
  endfunction : cab_cond

  // ----------------------------------------
  // State
  // ----------------------------------------
  cab_core_st_t s_q;
  cab_core_st_t s_d;
  logic         tick;
  logic         step;
  logic         exec_now;
  logic         fetch_now;
  logic         wake_any;
  cab_op_t      op_x;
  cab_mode_t    mode_x;
  logic [15:0]  cur_ptr;
  logic [7:0]   src_reg;
  logic         jump_ok;

  // RULE3 step rate divider
  cab_clkdiv u_div (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .div_sel (s_q.div),
    .tick    (tick)
  );

  assign step      = tick & s_q.run;
  assign exec_now  = step && (s_q.fsm == CAB_EXEC);
  assign fetch_now = step && (s_q.fsm == CAB_FETCH);
  assign wake_any  = wake_irq | s_q.lz_sync | s_q.lo_sync | s_q.wake;
  assign op_x      = cab_op_t'(s_q.ir[`CAB_F_OP]);
  assign mode_x    = cab_mode_t'(s_q.ir[`CAB_F_MODE]);
  assign cur_ptr   = cab_ptr(s_q.rf, s_q.ir[`CAB_F_PSEL]);
  assign src_reg   = s_q.rf[s_q.ir[`CAB_F_REG]];
  assign jump_ok   = cab_cond(cab_cond_t'(s_q.ir[`CAB_F_REG]), s_q.c, s_q.v, s_q.z,
                              s_q.lz_sync | s_q.lo_sync);

  always_comb begin
    logic [31:0] ea;
    logic [10:0] cr;
    logic [9:0]  sr;
    logic [7:0]  opd;
    logic [12:0] pc_n;
    logic [3:0]  lo;
    ea   = '0;
    cr   = '0;
    sr   = '0;
    opd  = '0;
    pc_n = s_q.pc;
    lo   = '0;
    s_d  = s_q;
    s_d.wake    = 1'b0;
    s_d.lz_meta = event_line_zero;
    s_d.lz_sync = s_q.lz_meta;
    s_d.lo_meta = event_line_one;
    s_d.lo_sync = s_q.lo_meta;

    // ----------------------------------------
    // AXI4-Lite write, address and data in either order
    // ----------------------------------------
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got  = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got  = 1'b1;
      s_d.wbyte  = s_axi_wdata[7:0];
      s_d.w_lane = s_axi_wstrb[0];
      s_d.wready = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `CAB_RESP_OK;
      case (s_q.awaddr)
        `CAB_OFF_CTRL: if (s_q.w_lane) begin
          s_d.run  = s_q.wbyte[`CAB_CTRL_RUN];
          s_d.wake = s_q.wbyte[`CAB_CTRL_WAKE];
        end
        // Cleared here first so a same-cycle fault below still wins
        `CAB_OFF_STAT: if (s_q.w_lane && s_q.wbyte[`CAB_STAT_ERR]) begin
          s_d.dm_err = 1'b0;
        end
        `CAB_OFF_PC, `CAB_OFF_ACC: ;
        default: s_d.bresp = `CAB_RESP_ERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = `CAB_RESP_OK;
      s_d.rdata   = '0;
      case (s_axi_araddr)
        `CAB_OFF_CTRL: s_d.rdata[`CAB_CTRL_RUN] = s_q.run;
        `CAB_OFF_STAT: begin
          s_d.rdata[`CAB_STAT_Z]    = s_q.z;
          s_d.rdata[`CAB_STAT_V]    = s_q.v;
          s_d.rdata[`CAB_STAT_C]    = s_q.c;
          s_d.rdata[`CAB_STAT_HALT] = (s_q.fsm == CAB_HALT);
          s_d.rdata[`CAB_STAT_ERR]  = s_q.dm_err;
          s_d.rdata[`CAB_STAT_DIV]  = s_q.div;
        end
        `CAB_OFF_PC:  s_d.rdata[`CAB_PCW-1:0] = s_q.pc;
        `CAB_OFF_ACC: s_d.rdata[7:0] = s_q.rf[`CAB_RF_A];
        default:      s_d.rresp = `CAB_RESP_ERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // ----------------------------------------
    // Instruction sequencer
    // ----------------------------------------
    unique case (s_q.fsm)
      CAB_FETCH: if (step) begin
        // RULE14 fetch latch and data strobe together
        s_d.ir = imem_data;
        ea = cab_eaddr(cab_mode_t'(imem_data[`CAB_F_MODE]),
                       cab_ptr(s_q.rf, imem_data[`CAB_F_PSEL]),
                       imem_data[`CAB_F_OFS], s_q.rf[`CAB_RF_THIRD]);
        s_d.dm_addr  = ea[31:16];
        s_d.new_ptr  = ea[15:0];
        s_d.dm_wdata = s_q.rf[imem_data[`CAB_F_REG]];
        if (cab_mem_op(imem_data[`CAB_F_OP])) begin
          if (cab_dm_ok(ea[31:16])) begin
            s_d.dm_we = (imem_data[`CAB_F_OP] == CAB_STORE);
            s_d.dm_re = (imem_data[`CAB_F_OP] != CAB_STORE);
          end else begin
            s_d.dm_err = 1'b1;
          end
        end
        s_d.fsm = CAB_EXEC;
      end
      CAB_EXEC: if (step) begin
        opd = s_q.dm_re ? dm_rdata : 8'h00;
        // RULE15 13-bit counter wraps at 8192
        pc_n = s_q.pc + 13'h0001;
        s_d.dm_re = 1'b0;
        s_d.dm_we = 1'b0;
        s_d.fsm   = CAB_FETCH;
        // RULE17 internal register file
        case (op_x)
          CAB_LD:   s_d.rf[s_q.ir[`CAB_F_REG]] = opd;
          CAB_MOVI: s_d.rf[s_q.ir[`CAB_F_REG]] = s_q.ir[`CAB_F_OFS];
          CAB_CMP, CAB_CMPI: begin
            // RULE18 operand two minus operand one
            cr = cab_cmp((op_x == CAB_CMP) ? opd : s_q.ir[`CAB_F_OFS], src_reg);
            {s_d.c, s_d.v, s_d.z, s_d.rf[`CAB_RF_A]} = cr;
          end
          CAB_RFLR, CAB_RFLM: begin
            // RULE2 shift into carry
            sr = cab_shl((op_x == CAB_RFLM) ? opd : src_reg);
            {s_d.c, s_d.z, s_d.rf[`CAB_RF_A]} = sr;
            s_d.v = 1'b0;
          end
          // RULE1 flag snapshot
          CAB_SFLAG: s_d.rf[`CAB_RF_A] = {s_q.c, s_q.c ^ s_q.v, hardware_call_stack_full,
                                          hardware_call_stack_empty, 4'h0};
          // RULE3 new divide code
          CAB_FREQ:  s_d.div = s_q.ir[`CAB_F_DIV];
          // RULE19 enter halt
          CAB_HALTI: s_d.fsm = CAB_HALT;
          CAB_JCC:   if (jump_ok) begin
            pc_n = s_q.ir[`CAB_F_TGT];
          end
          default: ;
        endcase
        // RULE5 pointer update in same step
        if (cab_mem_op(s_q.ir[`CAB_F_OP])) begin
          lo = `CAB_RF_PTR0 + {1'b0, s_q.ir[`CAB_F_PSEL], 1'b0};
          s_d.rf[lo]        = s_q.new_ptr[7:0];
          s_d.rf[lo + 4'h1] = s_q.new_ptr[15:8];
        end
        s_d.pc        = pc_n;
        s_d.imem_addr = pc_n;
      end
      // RULE19 wait for wake
      CAB_HALT: if (wake_any) begin
        s_d.fsm = CAB_FETCH;
      end
      default: s_d.fsm = CAB_FETCH;
    endcase

    if (!nrst) begin
      s_d         = '0;
      s_d.fsm     = CAB_FETCH;
      s_d.pc      = `CAB_PC_RST;
      s_d.imem_addr = `CAB_PC_RST;
      s_d.run     = 1'b1;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign imem_addr     = s_q.imem_addr;
  assign dm_addr       = s_q.dm_addr;
  assign dm_wdata      = s_q.dm_wdata;
  assign dm_re         = s_q.dm_re;
  assign dm_we         = s_q.dm_we;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rvalid  = s_q.rvalid;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_SFLAG: assert property ( // RULE1
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && op_x == CAB_SFLAG) |=> (s_q.rf[`CAB_RF_A] == {$past(s_q.c),
      $past(s_q.c) ^ $past(s_q.v), $past(hardware_call_stack_full),
      $past(hardware_call_stack_empty), 4'h0}) && $stable({s_q.c, s_q.v, s_q.z}))
    else $error("flag snapshot wrong");

  AST_SHIFT: assert property ( // RULE2
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && (op_x == CAB_RFLR || (op_x == CAB_RFLM && s_q.dm_re))) |=>
      ({s_q.c, s_q.rf[`CAB_RF_A]} == {$past((op_x == CAB_RFLM) ? dm_rdata : src_reg), 1'b0}))
    else $error("shift into carry wrong");

  AST_FREQ: assert property ( // RULE3
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && op_x == CAB_FREQ)
    |=> (s_q.div == $past(s_q.ir[`CAB_F_DIV])) && $stable({s_q.c, s_q.v, s_q.z}))
    else $error("divide select wrong");

  AST_DIRECT: assert property ( // RULE4
    @(posedge ref_clk) disable iff (!nrst)
    (fetch_now && imem_data[`CAB_F_MODE] == CAB_M_DIRECT)
    |=> s_q.dm_addr == {`CAB_DIRECT_HI, $past(imem_data[`CAB_F_OFS])})
    else $error("direct address wrong");

  AST_POSTINC: assert property ( // RULE8
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && mode_x == CAB_M_POSTINC && cab_mem_op(s_q.ir[`CAB_F_OP]))
    |-> (s_q.dm_addr == cur_ptr) ##1 (cur_ptr == $past(cur_ptr) + 16'h0001))
    else $error("post increment wrong");

  AST_PREDEC: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && mode_x == CAB_M_PREDEC && cab_mem_op(s_q.ir[`CAB_F_OP]))
    |-> (s_q.dm_addr == cur_ptr - 16'h0001) ##1 (cur_ptr == $past(s_q.dm_addr)))
    else $error("pre decrement wrong");

  AST_OFFKEEP: assert property ( // RULE6
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && mode_x == CAB_M_PTROFF && cab_mem_op(s_q.ir[`CAB_F_OP]))
    |-> (s_q.dm_addr == cur_ptr + {8'h00, s_q.ir[`CAB_F_OFS]}) ##1 $stable(cur_ptr))
    else $error("offset mode moved pointer");

  AST_JUMP: assert property ( // RULE12
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && op_x == CAB_JCC && jump_ok) |=> s_q.imem_addr == $past(s_q.ir[`CAB_F_TGT]))
    else $error("taken jump missed target");

  AST_CMPI: assert property ( // RULE18
    @(posedge ref_clk) disable iff (!nrst)
    (exec_now && op_x == CAB_CMPI)
    |=> (s_q.c == ($past(s_q.ir[`CAB_F_OFS]) >= $past(src_reg))) && (s_q.v == (s_q.c && !s_q.z)))
    else $error("compare flags wrong");

  AST_RANGE: assert property ( // RULE16
    @(posedge ref_clk) disable iff (!nrst)
    (s_q.dm_re || s_q.dm_we) |-> cab_dm_ok(s_q.dm_addr))
    else $error("strobe outside data space");

  AST_HALT: assert property ( // RULE19
    @(posedge ref_clk) disable iff (!nrst)
    (s_q.fsm == CAB_HALT && !wake_any) |=> (s_q.fsm == CAB_HALT) && $stable(s_q.pc)
      && $stable(s_q.rf) && !s_q.dm_re && !s_q.dm_we)
    else $error("halted core moved");
endmodule : cab_core

//--- cab_regs.svh
// Constants of the addressing and branch core
`ifndef CAB_REGS_SVH
`define CAB_REGS_SVH
`define CAB_IW       22
`define CAB_PCW      13
`define CAB_DAW      16
`define CAB_F_OP     21:18
`define CAB_F_REG    17:14
`define CAB_F_MODE   13:11
`define CAB_F_PSEL   10:9
`define CAB_F_OFS    7:0
`define CAB_F_TGT    12:0
`define CAB_F_DIV    2:0
`define CAB_RF_THIRD 4'h3
`define CAB_RF_PTR0  4'h4
`define CAB_RF_A     4'hf
`define CAB_DIRECT_HI 8'h00
`define CAB_LP_TOP   16'h0007
`define CAB_PER_BASE 16'h0010
`define CAB_RAM_TOP  16'h027f
`define CAB_PC_RST   13'h0000
`define CAB_OFF_CTRL 8'h00
`define CAB_OFF_STAT 8'h04
`define CAB_OFF_PC   8'h08
`define CAB_OFF_ACC  8'h0c
`define CAB_CTRL_RUN  0
`define CAB_CTRL_WAKE 1
`define CAB_STAT_Z    0
`define CAB_STAT_V    1
`define CAB_STAT_C    2
`define CAB_STAT_HALT 3
`define CAB_STAT_ERR  4
`define CAB_STAT_DIV  7:5
`define CAB_RESP_OK  2'b00
`define CAB_RESP_ERR 2'b10
`endif

//--- cab_pkg.sv
// Types of the addressing and branch core
`include "cab_regs.svh"
package cab_pkg;
  typedef enum logic [2:0] {
    CAB_FETCH = 3'b001,
    CAB_EXEC  = 3'b010,
    CAB_HALT  = 3'b100
  } cab_state_t;

  typedef enum logic [3:0] {
    CAB_NOP   = 4'h0,
    CAB_LD    = 4'h1,
    CAB_STORE = 4'h2,
    CAB_CMP   = 4'h3,
    CAB_CMPI  = 4'h4,
    CAB_RFLR  = 4'h5,
    CAB_RFLM  = 4'h6,
    CAB_SFLAG = 4'h7,
    CAB_FREQ  = 4'h8,
    CAB_HALTI = 4'h9,
    CAB_JCC   = 4'ha,
    CAB_MOVI  = 4'hb
  } cab_op_t;

  typedef enum logic [2:0] {
    CAB_M_DIRECT  = 3'h0,
    CAB_M_PTR     = 3'h1,
    CAB_M_PTROFF  = 3'h2,
    CAB_M_PTRTHRD = 3'h3,
    CAB_M_POSTINC = 3'h4,
    CAB_M_POSTOFF = 3'h5,
    CAB_M_PREDEC  = 3'h6,
    CAB_M_PREOFF  = 3'h7
  } cab_mode_t;

  typedef enum logic [3:0] {
    CAB_C_CS = 4'h0, CAB_C_CC = 4'h1, CAB_C_ZS = 4'h2, CAB_C_ZC = 4'h3,
    CAB_C_VS = 4'h4, CAB_C_VC = 4'h5, CAB_C_EVENT = 4'h6, CAB_C_EQ = 4'h7,
    CAB_C_NE = 4'h8, CAB_C_GT = 4'h9, CAB_C_GE = 4'ha, CAB_C_LT = 4'hb,
    CAB_C_LE = 4'hc
  } cab_cond_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } cab_div_st_t;

  typedef struct packed {
    cab_state_t                fsm;
    logic [`CAB_PCW-1:0]       pc;
    logic [`CAB_PCW-1:0]       imem_addr;
    logic [`CAB_IW-1:0]        ir;
    logic [15:0][7:0]          rf;
    logic                      c, v, z;
    logic [2:0]                div;
    logic [`CAB_DAW-1:0]       dm_addr;
    logic [7:0]                dm_wdata;
    logic                      dm_re, dm_we;
    logic [`CAB_DAW-1:0]       new_ptr;
    logic                      run, wake, dm_err;
    logic                      lz_meta, lz_sync, lo_meta, lo_sync;
    logic                      awready, wready, bvalid, arready, rvalid;
    logic                      aw_got, w_got, w_lane;
    logic [1:0]                bresp, rresp;
    logic [7:0]                awaddr, wbyte;
    logic [31:0]               rdata;
  } cab_core_st_t;
endpackage : cab_pkg

//--- cab_clkdiv.sv
// CPU step enable divider
`timescale 1ns/100ps
`include "cab_regs.svh"
module cab_clkdiv
  import cab_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  cab_div_st_t s_q;
  cab_div_st_t s_d;
  logic [3:0]  mask;

  always_comb begin
    s_d = s_q;
    case (div_sel)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hf;
    endcase
    s_d.cnt  = s_q.cnt + 4'h1;
    s_d.tick = ((s_q.cnt & mask) == mask);
    if (!nrst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule : cab_clkdiv

//--- cab_mem_model.sv
// Instruction and data memory model facing the core
`timescale 1ns/100ps
`include "cab_regs.svh"
module cab_mem_model (
  input  wire logic                ref_clk,
  input  wire logic [`CAB_PCW-1:0] imem_addr,
  output logic [`CAB_IW-1:0]       imem_data,
  input  wire logic [`CAB_DAW-1:0] dm_addr,
  input  wire logic [7:0]          dm_wdata,
  output logic [7:0]               dm_rdata,
  input  wire logic                dm_re,
  input  wire logic                dm_we
);
  logic [`CAB_IW-1:0] imem [8192];
  logic [7:0]         dmem [640];
  logic [7:0]         junk = 8'h5a;
  assign imem_data = imem[imem_addr];
  // Unselected bus churns, so a stale byte never passes
  assign dm_rdata = dm_re ? dmem[dm_addr] : junk;
  always @(posedge ref_clk) begin
    junk <= junk + 8'h35;
    if (dm_we) dmem[dm_addr] <= dm_wdata;
  end
endmodule : cab_mem_model

//--- cab_core_tb.sv
// Self-checking bench for the addressing and branch core
`timescale 1ns/100ps
`include "cab_regs.svh"
module cab_core_tb import cab_pkg::*;;
  logic        ref_clk = 1'b0, nrst = 1'b0;
  logic [12:0] imem_addr;
  logic [21:0] imem_data;
  logic [15:0] dm_addr;
  logic [7:0]  dm_wdata, dm_rdata, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        dm_re, dm_we, event_line_zero = 1'b0, event_line_one = 1'b0, wake_irq = 1'b0;
  logic        hardware_call_stack_full = 1'b1, hardware_call_stack_empty = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          miscompares = 0, n_compared = 0, pc = 0;
  logic [12:0] hp [5];
  logic [7:0]  imms [3] = '{8'h11, 8'h20, 8'h05};
  logic [12:0] masks [3] = '{13'h14a5, 13'h1919, 13'h072a};
  logic [15:0] dexp [8] = '{16'h0012, 16'h8210, 16'h8412, 16'h8511, 16'h0511, 16'h0682,
                            16'h0214, 16'h07e0};

  cab_core u_cab_core (.ref_clk, .nrst, .imem_addr, .imem_data, .dm_addr, .dm_wdata, .dm_rdata,
    .dm_re, .dm_we, .event_line_zero, .event_line_one, .wake_irq, .hardware_call_stack_full,
    .hardware_call_stack_empty, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  cab_mem_model u_cab_mem_model (.ref_clk, .imem_addr, .imem_data, .dm_addr, .dm_wdata,
    .dm_rdata, .dm_re, .dm_we);

  initial forever #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, ex, g);
    end
  endtask : chk

  function automatic logic [21:0] ins(input logic [3:0] op, input logic [3:0] rg,
                                      input logic [2:0] m, input logic [1:0] ps,
                                      input logic [7:0] o);
    return {op, rg, m, ps, 1'b0, o};
  endfunction : ins

  task automatic e(input logic [21:0] w);
    u_cab_mem_model.imem[pc] = w;
    pc++;
  endtask : e

  // Taken jumps hop over a halt, untaken ones aim at a far trap
  task automatic jt(input logic [3:0] c, input logic t);
    e({4'ha, c, 1'b0, t ? 13'(pc + 2) : 13'h1ff0});
    if (t) pc++;
  endtask : jt

  task automatic wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wait_halt(input logic [12:0] p);
    logic [31:0] q;
    do rd(8'h04, d, r); while (!d[3]);
    rd(8'h08, q, r);
    repeat (50) @(posedge ref_clk);
    rd(8'h08, d, r);
    chk("halt_pc_held", q, d);
    chk("halt_pc", 32'(p) + 32'h1, d);
  endtask : wait_halt

  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    $display("MISMATCH watchdog expected finish seen timeout");
    conclude();
  end

  // ----------------------------------------
  // Program and sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 8192; i++) u_cab_mem_model.imem[i] = 22'h240000;
    for (int i = 0; i < 6; i++) u_cab_mem_model.dmem[8'h80 + i] = 8'h10 + 8'(i);
    u_cab_mem_model.dmem[8'h90] = 8'hc5;
    e(ins(CAB_MOVI, 4'h4, 3'h0, 2'h0, 8'h80));
    e(ins(CAB_MOVI, 4'h5, 3'h0, 2'h0, 8'h00));
    e(ins(CAB_MOVI, 4'h3, 3'h0, 2'h0, 8'h02));
    e(ins(CAB_LD, 4'h0, CAB_M_PTROFF, 2'h0, 8'h01));
    e(ins(CAB_LD, 4'h1, CAB_M_PTRTHRD, 2'h0, 8'h00));
    e(ins(CAB_LD, 4'h2, CAB_M_POSTINC, 2'h0, 8'h00));
    e(ins(CAB_STORE, 4'h0, CAB_M_POSTOFF, 2'h0, 8'h04));
    e(ins(CAB_STORE, 4'h1, CAB_M_PREDEC, 2'h0, 8'h00));
    e(ins(CAB_STORE, 4'h2, CAB_M_PREOFF, 2'h0, 8'h02));
    e(ins(CAB_STORE, 4'h1, CAB_M_PTR, 2'h1, 8'h00));
    e(ins(CAB_STORE, 4'h0, CAB_M_DIRECT, 2'h0, 8'h05));
    e(ins(CAB_STORE, 4'h4, CAB_M_DIRECT, 2'h0, 8'h06));
    e(ins(CAB_STORE, 4'h0, CAB_M_DIRECT, 2'h0, 8'h08));
    e(ins(CAB_RFLM, 4'h0, CAB_M_DIRECT, 2'h0, 8'h90));
    e(ins(CAB_RFLR, 4'hf, 3'h0, 2'h0, 8'h00));
    e(ins(CAB_STORE, 4'hf, CAB_M_DIRECT, 2'h0, 8'h02));
    e(ins(CAB_SFLAG, 4'h0, 3'h0, 2'h0, 8'h00));
    e(ins(CAB_STORE, 4'hf, CAB_M_DIRECT, 2'h0, 8'h07));
    for (int k = 0; k < 3; k++) begin
      e(ins(CAB_CMPI, 4'h0, 3'h0, 2'h0, imms[k]));
      for (int c = 0; c < 13; c++) jt(4'(c), masks[k][c]);
    end
    e(ins(CAB_FREQ, 4'h0, 3'h0, 2'h0, 8'h04));
    for (int k = 0; k < 4; k++) begin
      hp[k] = 13'(pc);
      e(22'h240000);
      jt(CAB_C_EVENT, k < 2);
      repeat (4) e(22'h000000);
    end
    hp[4] = 13'(pc);
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_halt(hp[0]);
    for (int i = 0; i < 8; i++) begin
      d = 32'(u_cab_mem_model.dmem[dexp[i][15:8]]);
      if (i < 4) chk("dmem", 32'(dexp[i][7:0]), d);
      else chk("dmem", 32'(dexp[i][7:0]), d);
    end
    rd(8'h0c, d, r);
    chk("acc", 32'h000000f4, d);
    rd(8'h04, d, r);
    chk("status", 32'h00000098, d);
    chk("rd_resp", 32'h0, 32'(r));
    wr(8'h04, 32'h00000010, r);
    chk("wr_resp", 32'h0, 32'(r));
    rd(8'h04, d, r);
    chk("status_clr", 32'h00000088, d);
    rd(8'h10, d, r);
    chk("unmapped_rd", 32'h2, 32'(r));
    wr(8'h20, 32'h1, r);
    chk("unmapped_wr", 32'h2, 32'(r));
    for (int k = 0; k < 4; k++) begin
      event_line_zero <= (k == 0);
      event_line_one <= (k == 1);
      wake_irq <= (k == 3);
      if (k == 2) wr(8'h00, 32'h00000003, r);
      do rd(8'h08, d, r); while (d[12:0] < hp[k] + 13'h2);
      event_line_zero <= 1'b0;
      event_line_one <= 1'b0;
      wake_irq <= 1'b0;
      wait_halt(hp[k + 1]);
    end
    conclude();
  end
endmodule : cab_core_tb
